// ==== verilog/serial_control_port_slave.v ====
// Serial control port slave: instruction decode, data phase, stall and abort handling.
// Assumes serial clock, chip select and data pins are asynchronous to clock and far slower.
// Contract
// R1 - Sample on rising edge, launch on falling.
// R2 - Unidirectional after reset until bit seven set.
// R3 - Unidirectional readback goes out on separate pin.
// R4 - Bidirectional mode turns shared pin for reads.
// R5 - Chip select high floats both outputs.
// R6 - Sixteen-bit instruction opens every cycle.
// R7 - Instruction gives direction, count, address.
// R8 - Host stalls only on byte boundaries.
// R9 - Stall waits, resumes when select lowers.
// R10 - Short select pulse aborts a stall.
// R11 - Mid-byte select rise resets, discards partial.
// R12 - Streaming accepts any bytes, steps address.
// R13 - Rise after final byte ends cycle.
// R14 - Streaming visits reserved and blank addresses.
// R15 - Staged group applied by self-clearing strobe.
// R16 - Parameter pair applied on toggle rise.
// R17 - Read shifts N bytes or streams.
// R18 - Readback from buffer or active copy.
// R19 - Long instruction bits read one, fixed.
// R20 - Addresses 0x00 to 0x55 implemented.
// R21 - Instruction: direction, count, thirteen-bit address.
// R22 - Address steps down MSB-first, up LSB-first.
// R23 - Streaming stops at address 0x2F.
// R24 - LSB order bits mirrored, effective immediately.
// R25 - New cycle restarts in instruction phase.
`timescale 1ns/1ns
`include "scp_map.vh"
module serial_control_port_slave #(
    parameter AW = 7
) (
    // Clock and reset
    input  wire       clock,
    input  wire       nrst,
    // Serial pins
    input  wire       sclk,
    input  wire       cs_n,
    input  wire       sdio_in,
    output reg        sdio_out,
    output reg        sdio_oe,
    output reg        sdo_out,
    output reg        sdo_oe,
    // Status
    output reg        bidir_mode,
    output reg        lsb_order_select,
    output reg        frequency_update_strobe,
    output reg        parameter_update_toggle,
    output reg        cycle_active
);
    localparam ST_IDLE  = 2'd0;
    localparam ST_INSTR = 2'd1;
    localparam ST_DATA  = 2'd2;
    localparam ST_STALL = 2'd3;

    reg [1:0] sclk_s_r;
    reg [1:0] cs_s_r;
    reg [1:0] sdi_s_r;
    reg [1:0] sdio_s_r;
    reg       sclk_d_r;
    reg       cs_d_r;

    reg [1:0]    state_r;
    reg [3:0]    bit_cnt_r;
    reg [15:0]   shift_r;
    reg          is_read_r;
    reg          stream_r;
    reg [1:0]    bytes_left_r;
    reg [AW-1:0] addr_r;
    reg          stall_instr_r;
    reg [3:0]    abort_cnt_r;
    reg [7:0]    tx_r;
    reg          load_tx_r;
    reg          wr_en_r;
    reg [7:0]    wdata_r;
    reg [AW-1:0] wr_addr_r;
    reg          load_tx_d_r;
    reg          rd_tail_r;
    reg          par_prev_r;
    reg          freq_apply_r;
    reg          par_apply_r;

    wire [7:0] rdata;
    wire [7:0] ctrl_value;
    // A written byte lands at the address it arrived for, even after the pointer has moved on.
    wire [AW-1:0] reg_addr = wr_en_r ? wr_addr_r : addr_r;

    wire sclk_rise = sclk_s_r[1] & ~sclk_d_r;
    wire sclk_fall = ~sclk_s_r[1] & sclk_d_r;
    wire cs_fall   = ~cs_s_r[1] & cs_d_r;
    wire cs_rise   = cs_s_r[1] & ~cs_d_r;
    wire cs_low    = ~cs_s_r[1];
    wire bidir     = ctrl_value[`SCP_BIT_BIDIR];
    // The mirrored pair is required to agree; either copy selects LSB-first order.
    wire lsb_first = ctrl_value[`SCP_BIT_LSB_HI] | ctrl_value[`SCP_BIT_LSB_LO]; // R24
    wire rx_bit    = bidir ? sdio_s_r[1] : sdi_s_r[1];
    wire rd_drive  = rd_tail_r | (state_r == ST_DATA && is_read_r);

    // Bits enter at the top in LSB-first order and at the bottom otherwise.
    wire [15:0] shift_nxt = lsb_first ? {rx_bit, shift_r[15:1]} : {shift_r[14:0], rx_bit};
    wire [7:0]  byte_nxt  = lsb_first ? shift_nxt[15:8] : shift_nxt[7:0];
    wire [AW-1:0] addr_step = lsb_first ? addr_r + 1'b1 : addr_r - 1'b1; // R22

    scp_regfile #(
        .AW (AW)
    ) u_regs (
        .clock      (clock),
        .nrst       (nrst),
        .wr_en      (wr_en_r),
        .addr       (reg_addr),
        .wdata      (wdata_r),
        .rdata_r    (rdata),
        .freq_apply (freq_apply_r),
        .par_apply  (par_apply_r),
        .ctrl_value (ctrl_value)
    );

    // Pin synchronisers.
    always @(posedge clock) begin
        if (!nrst) begin
            sclk_s_r <= 2'b00;
            cs_s_r   <= 2'b11;
            sdi_s_r  <= 2'b00;
            sdio_s_r <= 2'b00;
            sclk_d_r <= 1'b0;
            cs_d_r   <= 1'b1;
        end else begin
            sclk_s_r <= {sclk_s_r[0], sclk};
            cs_s_r   <= {cs_s_r[0], cs_n};
            sdi_s_r  <= {sdi_s_r[0], sdio_in};
            sdio_s_r <= {sdio_s_r[0], sdio_in};
            sclk_d_r <= sclk_s_r[1];
            cs_d_r   <= cs_s_r[1];
        end
    end

    always @(posedge clock) begin
        if (!nrst) begin
            state_r       <= ST_IDLE;
            bit_cnt_r     <= 4'h0;
            shift_r       <= 16'h0000;
            is_read_r     <= 1'b0;
            stream_r      <= 1'b0;
            bytes_left_r  <= 2'd0;
            addr_r        <= {AW{1'b0}};
            stall_instr_r <= 1'b0;
            abort_cnt_r   <= 4'h0;
            load_tx_r     <= 1'b0;
            wr_en_r       <= 1'b0;
            wdata_r       <= 8'h00;
            wr_addr_r     <= {AW{1'b0}};
            freq_apply_r  <= 1'b0;
            par_apply_r   <= 1'b0;
            par_prev_r    <= 1'b0;
        end else begin
            wr_en_r      <= 1'b0;
            load_tx_r    <= 1'b0;
            freq_apply_r <= 1'b0;
            par_apply_r  <= 1'b0;
            // Byte written last cycle: apply the update strobes.
            if (wr_en_r && wr_addr_r == `SCP_REG_FREQ_UPD && wdata_r[`SCP_BIT_UPDATE])
                freq_apply_r <= 1'b1; // R15
            if (wr_en_r && wr_addr_r == `SCP_REG_PAR_UPD) begin
                par_prev_r <= wdata_r[`SCP_BIT_UPDATE];
                if (wdata_r[`SCP_BIT_UPDATE] && !par_prev_r)
                    par_apply_r <= 1'b1; // R16
            end
            case (state_r)
                ST_IDLE: begin
                    // Only a new select edge opens a cycle; clocks after a finished one are ignored.
                    if (cs_fall) begin
                        state_r   <= ST_INSTR; // R25
                        bit_cnt_r <= 4'h0;
                    end
                end
                ST_INSTR: begin
                    if (cs_rise) begin
                        // In the instruction phase, stalls are legal only between its two bytes.
                        if (bit_cnt_r == 4'd8) begin
                            state_r       <= ST_STALL; // R8
                            stall_instr_r <= 1'b1;
                            abort_cnt_r   <= 4'h0;
                        end else begin
                            state_r <= ST_IDLE; // R11
                        end
                    end else if (sclk_rise) begin // R1
                        shift_r   <= shift_nxt;
                        bit_cnt_r <= bit_cnt_r + 4'd1;
                        if (bit_cnt_r == 4'd15) begin // R6
                            // R21: flag, two-bit count, address of which the low bits are used.
                            is_read_r    <= shift_nxt[15]; // R7
                            stream_r     <= &shift_nxt[14:13]; // R17
                            bytes_left_r <= shift_nxt[14:13];
                            addr_r       <= shift_nxt[AW-1:0];
                            bit_cnt_r    <= 4'h0;
                            state_r      <= ST_DATA;
                            load_tx_r    <= shift_nxt[15];
                        end
                    end
                end
                ST_DATA: begin
                    if (cs_rise) begin
                        if (bit_cnt_r == 4'd0 && !stream_r) begin
                            state_r       <= ST_STALL; // R9
                            stall_instr_r <= 1'b0;
                            abort_cnt_r   <= 4'h0;
                        end else begin
                            state_r <= ST_IDLE; // R11 R12
                        end
                    end else if (sclk_rise) begin
                        shift_r   <= shift_nxt;
                        bit_cnt_r <= (bit_cnt_r == 4'd7) ? 4'h0 : bit_cnt_r + 4'd1;
                        if (bit_cnt_r == 4'd7) begin
                            if (!is_read_r) begin
                                wr_en_r <= 1'b1;
                                wdata_r <= byte_nxt;
                                wr_addr_r <= addr_r;
                            end
                            if (stream_r) begin
                                // Reserved and blank addresses are walked through too.
                                // Going down, the pointer wraps from zero to the stop address.
                                addr_r <= (addr_r == {AW{1'b0}} && !lsb_first) ?
                                          `SCP_REG_STOP : addr_step; // R14 R23
                                if (addr_r == `SCP_REG_STOP)
                                    state_r <= ST_IDLE; // R23
                                else
                                    load_tx_r <= is_read_r; // R12 R17
                            end else if (bytes_left_r == 2'd0) begin
                                state_r <= ST_IDLE; // R13
                            end else begin
                                bytes_left_r <= bytes_left_r - 2'd1;
                                addr_r       <= addr_step;
                                load_tx_r    <= is_read_r;
                            end
                        end
                    end
                end
                default: begin
                    // Stalled: a few clocks with select low then high aborts.
                    if (cs_low && sclk_rise && abort_cnt_r != 4'hf)
                        abort_cnt_r <= abort_cnt_r + 4'd1;
                    if (cs_rise && abort_cnt_r != 4'h0 && abort_cnt_r < `SCP_ABORT_MAX) begin
                        state_r <= ST_IDLE; // R10
                    end else if (cs_low && sclk_rise) begin
                        state_r   <= stall_instr_r ? ST_INSTR : ST_DATA;
                        shift_r   <= shift_nxt;
                        bit_cnt_r <= stall_instr_r ? 4'd9 : 4'd1;
                    end
                end
            endcase
        end
    end

    // Read byte launched bit by bit on falling serial clock edges.
    // The load waits one clock so that the register store has answered for the new address.
    always @(posedge clock) begin
        if (!nrst) begin
            tx_r        <= 8'h00;
            load_tx_d_r <= 1'b0;
            rd_tail_r   <= 1'b0;
            sdio_out    <= 1'b0;
            sdo_out     <= 1'b0;
            sdio_oe     <= 1'b0;
            sdo_oe      <= 1'b0;
        end else begin
            load_tx_d_r <= load_tx_r;
            // The last read bit must stand until the next falling edge, after the cycle ends.
            if (state_r == ST_DATA && is_read_r)
                rd_tail_r <= 1'b1;
            else if (sclk_fall || !cs_low)
                rd_tail_r <= 1'b0;
            if (load_tx_d_r)
                tx_r <= rdata;
            else if (sclk_fall && state_r == ST_DATA && is_read_r) begin // R1
                sdio_out <= lsb_first ? tx_r[0] : tx_r[7];
                sdo_out  <= lsb_first ? tx_r[0] : tx_r[7];
                tx_r     <= lsb_first ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
            end
            sdo_oe  <= cs_low && !bidir && rd_drive; // R2 R3 R5
            sdio_oe <= cs_low && bidir && rd_drive; // R4 R5
        end
    end

    always @(posedge clock) begin
        if (!nrst) begin
            bidir_mode              <= 1'b0;
            lsb_order_select        <= 1'b0;
            frequency_update_strobe <= 1'b0;
            parameter_update_toggle <= 1'b0;
            cycle_active            <= 1'b0;
        end else begin
            bidir_mode              <= bidir;
            lsb_order_select        <= lsb_first;
            frequency_update_strobe <= freq_apply_r;
            parameter_update_toggle <= par_prev_r;
            cycle_active            <= cs_low || state_r != ST_IDLE;
        end
    end
endmodule

// ==== verilog/scp_map.vh ====
// Constants of the serial control port: register offsets, field positions, reset values.
// Assumes inclusion by the port and its register store only.
`ifndef SCP_MAP_VH
`define SCP_MAP_VH
`define SCP_ADDR_W        7
`define SCP_INSTR_BITS    16
`define SCP_REG_CTRL      7'h00
`define SCP_REG_LAST      7'h55
`define SCP_REG_STOP      7'h2f
`define SCP_STAGE_FIRST   7'h16
`define SCP_STAGE_LAST    7'h1d
`define SCP_REG_FREQ_UPD  7'h1e
`define SCP_REG_PAR_A     7'h22
`define SCP_REG_PAR_B     7'h23
`define SCP_REG_PAR_UPD   7'h24
`define SCP_BIT_BIDIR     7
`define SCP_BIT_LSB_HI    6
`define SCP_BIT_LSB_LO    1
`define SCP_BIT_UPDATE    7
`define SCP_CTRL_RESET    8'h18
`define SCP_LONG_MASK     8'h18
`define SCP_ABORT_MAX     8
`endif

// ==== verilog/scp_regfile.v ====
// Register store of the serial control port: a buffer copy per address and active copies.
// Assumes writes come one byte at a time from the port on the system clock.
`timescale 1ns/1ns
`include "scp_map.vh"
module scp_regfile #(
    parameter AW = 7
) (
    // Clock and reset
    input  wire          clock,
    input  wire          nrst,
    // Port access
    input  wire          wr_en,
    input  wire [AW-1:0] addr,
    input  wire [7:0]    wdata,
    output reg  [7:0]    rdata_r,
    // Update strobes
    input  wire          freq_apply,
    input  wire          par_apply,
    // Control register view
    output wire [7:0]    ctrl_value
);
    reg [7:0] buf_mem [0:85];
    reg [7:0] act_mem [0:85];
    integer i;

    assign ctrl_value = act_mem[0];

    function is_staged;
        input [AW-1:0] a;
        begin
            is_staged = ((a >= `SCP_STAGE_FIRST) && (a <= `SCP_STAGE_LAST)) ||
                        (a == `SCP_REG_PAR_A) || (a == `SCP_REG_PAR_B);
        end
    endfunction

    always @(posedge clock) begin
        if (!nrst) begin
            for (i = 0; i < 86; i = i + 1) begin
                buf_mem[i] <= 8'h00;
                act_mem[i] <= 8'h00;
            end
            act_mem[0] <= `SCP_CTRL_RESET;
            rdata_r    <= 8'h00;
        end else begin
            if (wr_en && addr <= `SCP_REG_LAST) begin // R20
                buf_mem[addr] <= wdata;
                if (addr == `SCP_REG_CTRL)
                    act_mem[0] <= wdata | `SCP_LONG_MASK; // R19
                else if (addr == `SCP_REG_FREQ_UPD)
                    act_mem[addr] <= {1'b0, wdata[6:0]}; // R15
                else if (!is_staged(addr))
                    act_mem[addr] <= wdata;
            end
            if (freq_apply) begin
                for (i = `SCP_STAGE_FIRST; i <= `SCP_STAGE_LAST; i = i + 1)
                    act_mem[i] <= buf_mem[i]; // R15
            end
            if (par_apply) begin
                act_mem[`SCP_REG_PAR_A] <= buf_mem[`SCP_REG_PAR_A]; // R16
                act_mem[`SCP_REG_PAR_B] <= buf_mem[`SCP_REG_PAR_B];
            end
            // Staged registers read back their buffer copy, addresses above 0x55 read zero, the rest their active copy.
            if (addr > `SCP_REG_LAST)
                rdata_r <= 8'h00;
            else if (is_staged(addr))
                rdata_r <= buf_mem[addr]; // R18
            else
                rdata_r <= act_mem[addr];
        end
    end
endmodule

// ==== testbench/scp_slave_props.sv ====
// Checker of the serial control port slave, watching its ports only.
// Assumes the serial pins change far slower than clock, with sclk high and low for 4 clocks.
`timescale 1ns/1ns
module scp_slave_props (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Serial pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_in,
    input wire logic sdio_out,
    input wire logic sdio_oe,
    input wire logic sdo_out,
    input wire logic sdo_oe,
    // Status
    input wire logic bidir_mode,
    input wire logic lsb_order_select,
    input wire logic frequency_update_strobe,
    input wire logic parameter_update_toggle,
    input wire logic cycle_active
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    a_float_when_idle: assert property (cs_n [*8] |-> !sdio_oe && !sdo_oe)
        else $error("outputs driven while chip select is high");
    a_uni_no_sdio: assert property (!bidir_mode |-> !sdio_oe)
        else $error("shared pin driven in unidirectional mode");
    a_bidir_no_sdo: assert property (bidir_mode |-> !sdo_oe)
        else $error("separate output driven in bidirectional mode");
    // A read bit may only move shortly after a falling serial clock edge.
    a_launch_on_fall: assert property ($changed(sdo_out) && sdo_oe && $past(sdo_oe)
        |-> !$past(sclk, 2))
        else $error("read bit changed away from a falling serial clock edge");
    a_strobe_one_cycle: assert property (frequency_update_strobe |=> !frequency_update_strobe)
        else $error("frequency update strobe longer than one cycle");
    a_strobe_in_write: assert property ($rose(frequency_update_strobe)
        |-> !$past(cs_n, 3) && cycle_active)
        else $error("frequency update strobe outside a transfer");
    a_toggle_in_write: assert property ($changed(parameter_update_toggle)
        |-> !$past(cs_n, 3) && cycle_active)
        else $error("parameter toggle changed outside a transfer");
    a_oe_in_cycle: assert property (sdo_oe || sdio_oe |-> cycle_active)
        else $error("read data driven while the port is idle");
    a_reset_state: assert property ($rose(nrst) |-> !bidir_mode && !lsb_order_select)
        else $error("port modes not cleared by reset");

    cover property ($rose(sdo_oe));
    cover property ($rose(sdio_oe));
    cover property (frequency_update_strobe);
    cover property ($rose(lsb_order_select));
endmodule
bind serial_control_port_slave scp_slave_props i_props (.clock, .nrst, .sclk, .cs_n, .sdio_in,
    .sdio_out, .sdio_oe, .sdo_out, .sdo_oe, .bidir_mode, .lsb_order_select,
    .frequency_update_strobe, .parameter_update_toggle, .cycle_active);

// ==== testbench/scp_host.sv ====
// Host model driving the serial pins with an 80 ns serial clock.
// Assumes the bench resolves the shared pin and feeds the resolved levels back.
`timescale 1ns/1ns
module scp_host (
    // Serial pins driven
    output logic     sclk,
    output logic     cs_n,
    output logic     sdio_drv,
    // Lines seen
    input wire logic sdo_line,
    input wire logic sdio_line
);
    logic [7:0] dq [0:3];
    logic       lsb = 1'b0;
    logic       bi  = 1'b0;
    int         ak  = 0;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdio_drv = 1'b0;
    end
    // Data moves while sclk is low; read bits are taken late in the high phase.
    task automatic pulse(input logic b, output logic r);
        sdio_drv = b;
        #40 sclk = 1'b1;
        #39 r = bi ? sdio_line : sdo_line;
        #1 sclk = 1'b0;
    endtask
    // On a read the pin is left to a changing pattern, never the last driven value.
    task automatic byte_x(inout logic [7:0] d, input logic rd);
        logic r;
        for (int i = 0; i < 8; i++) begin
            pulse(rd ? ~sdio_drv : d[lsb ? i : 7 - i], r);
            if (rd) d[lsb ? i : 7 - i] = r;
        end
    endtask
    // A negative ak cuts the byte mid-way; a positive one aborts a stall with ak pulses.
    task automatic cyc(input logic rd, input logic [1:0] n, input logic [6:0] a,
                       input int nb, input int stall);
        logic [7:0] ih;
        logic [7:0] il;
        logic       r;
        ih = {rd, n, 5'h00};
        il = {1'b0, a};
        cs_n = 1'b0;
        #40;
        if (lsb) begin
            byte_x(il, 1'b0);
            byte_x(ih, 1'b0);
        end else begin
            byte_x(ih, 1'b0);
            byte_x(il, 1'b0);
        end
        for (int i = 0; i < nb; i++) begin
            if (i == stall) begin
                if (ak < 0) begin
                    repeat (-ak) pulse(dq[i][7], r);
                    cs_n = 1'b1;
                    #200;
                    return;
                end
                cs_n = 1'b1;
                #200 cs_n = 1'b0;
                #40;
                if (ak > 0) begin
                    repeat (ak) pulse(1'b0, r);
                    cs_n = 1'b1;
                    #200;
                    return;
                end
            end
            byte_x(dq[i], rd);
        end
        #40 cs_n = 1'b1;
        #200;
    endtask
endmodule

// ==== testbench/serial_control_port_slave_tb.sv ====
// Bench of the serial control port slave: the host model drives every transfer.
// Assumes the checker is bound to the design and the host runs unrelated to clock.
`timescale 1ns/1ns
module serial_control_port_slave_tb;
    logic clock = 1'b0;
    logic nrst  = 1'b0;
    int   fail_count = 0;
    int   checks     = 0;
    int   fq         = 0;
    wire  sclk, cs_n, drv, sdio_out, sdio_oe, sdo_out, sdo_oe;
    wire  bidir_mode, lsb_sel, fus, put, cycle_active;
    wire  sdio_w = sdio_oe ? sdio_out : drv;
    wire  sdo_w  = sdo_oe ? sdo_out : ~sdo_out;
    initial begin
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        if (fus === 1'b1) fq++;
    end
    scp_host host (.sclk(sclk), .cs_n(cs_n), .sdio_drv(drv), .sdo_line(sdo_w), .sdio_line(sdio_w));
    serial_control_port_slave i_dut (
        .clock(clock), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_w),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
        .bidir_mode(bidir_mode), .lsb_order_select(lsb_sel), .frequency_update_strobe(fus),
        .parameter_update_toggle(put), .cycle_active(cycle_active));
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.dq[0] = d;
        host.cyc(1'b0, 2'b00, a, 1, -1);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        host.cyc(1'b1, 2'b00, a, 1, -1);
        chk8(host.dq[0], e);
    endtask
    task automatic t_reset;
        chk1(bidir_mode, 1'b0);
        rd(7'h00, 8'h18);
        wr(7'h00, 8'h00);
        rd(7'h00, 8'h18);
        chk1(cycle_active, 1'b0);
    endtask
    task automatic t_multi;
        host.dq[0] = 8'ha5;
        host.dq[1] = 8'h3c;
        host.cyc(1'b0, 2'b01, 7'h0a, 2, 1);
        host.cyc(1'b1, 2'b01, 7'h0a, 2, 0);
        chk8(host.dq[0], 8'ha5);
        chk8(host.dq[1], 8'h3c);
    endtask
    task automatic t_cut;
        host.ak = -4;
        host.dq[0] = 8'hff;
        host.cyc(1'b0, 2'b00, 7'h0b, 1, 0);
        host.ak = 3;
        host.dq[0] = 8'h5e;
        host.cyc(1'b0, 2'b10, 7'h0c, 3, 1);
        host.ak = 0;
        host.cyc(1'b1, 2'b01, 7'h0c, 2, -1);
        chk8(host.dq[0], 8'h5e);
        chk8(host.dq[1], 8'h00);
        wr(7'h60, 8'hff);
        rd(7'h60, 8'h00);
    endtask
    task automatic t_lsb;
        wr(7'h00, 8'h5a);
        chk1(lsb_sel, 1'b1);
        host.lsb = 1'b1;
        host.dq = '{8'h11, 8'h22, 8'h33, 8'h44};
        host.cyc(1'b0, 2'b11, 7'h2d, 4, -1);
        host.cyc(1'b1, 2'b11, 7'h2d, 3, -1);
        chk8(host.dq[0], 8'h11);
        chk8(host.dq[1], 8'h22);
        chk8(host.dq[2], 8'h33);
        rd(7'h30, 8'h00);
        wr(7'h00, 8'h18);
        host.lsb = 1'b0;
        chk1(lsb_sel, 1'b0);
        host.dq = '{8'h6b, 8'h18, 8'h4d, 8'h00};
        host.cyc(1'b0, 2'b11, 7'h01, 3, -1);
        rd(7'h2f, 8'h4d);
        rd(7'h01, 8'h6b);
    endtask
    task automatic t_bidir;
        wr(7'h00, 8'h99);
        chk1(bidir_mode, 1'b1);
        host.bi = 1'b1;
        rd(7'h0a, 8'ha5);
        wr(7'h00, 8'h18);
        host.bi = 1'b0;
        chk1(bidir_mode, 1'b0);
        rd(7'h09, 8'h3c);
    endtask
    task automatic t_update;
        wr(7'h16, 8'h77);
        chk8(8'(fq), 8'h00);
        wr(7'h1e, 8'h80);
        chk8(8'(fq), 8'h01);
        rd(7'h1e, 8'h00);
        rd(7'h16, 8'h77);
        wr(7'h24, 8'h80);
        chk1(put, 1'b1);
        wr(7'h24, 8'h00);
        chk1(put, 1'b0);
    endtask
    task automatic end_of_test;
        if (fail_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clock);
        nrst = 1'b1;
        repeat (5) @(negedge clock);
        t_reset;
        t_multi;
        t_cut;
        t_lsb;
        t_bidir;
        t_update;
        end_of_test;
    end
    // About 30 transfers of a few microseconds each; over four times that is allowed.
    initial begin
        #300000;
        fail_count++;
        end_of_test;
    end
endmodule
